// ==== core/rtc_defs.svh ====
// Purpose: Offsets, field positions, rollover values and divider taps of the RTC block
// Assumes: Byte addresses on an Avalon-MM slave with 32-bit data, registers in the low byte
// Notes:   Definitions only; included by bare name
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

`define RTC_ADDR_W        5
`define RTC_OFS_SEC       5'h00
`define RTC_OFS_MIN       5'h04
`define RTC_OFS_HOUR      5'h08
`define RTC_OFS_WDAY      5'h0c
`define RTC_OFS_DATE      5'h10
`define RTC_OFS_PAGE      5'h14
`define RTC_OFS_CTRL      5'h18

`define RTC_PG_IRQ_EN     7
`define RTC_PG_ADJUST     4
`define RTC_PG_CNT_EN     3
`define RTC_PG_ALM_EN     2
`define RTC_PG_PAGE       0
`define RTC_PG_RD_MASK    8'h8d

`define RTC_CT_DIS_1HZ    7
`define RTC_CT_DIS_16HZ   6
`define RTC_CT_DIV_CLR    5
`define RTC_CT_ALM_CLR    4

`define RTC_SEC_TOP       8'h59
`define RTC_SEC_HALF      8'h30
`define RTC_MIN_TOP       8'h59
`define RTC_HOUR_TOP      8'h23
`define RTC_WDAY_TOP      8'h06
`define RTC_DATE_TOP      8'h31
`define RTC_ZERO          8'h00
`define RTC_DATE_BASE     8'h01

`define RTC_DIV_STAGES    15
`define RTC_16HZ_SHIFT    4

`endif

// ==== core/rtc_pkg.sv ====
// Purpose: Types shared by the RTC core, its property checks and its bench
// Assumes: Numbers live in rtc_defs.svh
// Notes:   Bus request travels as one packed struct
package rtc_pkg;

  typedef struct packed {
    logic       read;
    logic       write;
    logic [4:0] address;
    logic [7:0] writedata;
  } rtc_av_req_s;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] date;
  } rtc_time_s;

  typedef struct packed {
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] date;
  } rtc_alarm_s;

  typedef enum logic [3:0] {
    RTC_SRC_NONE  = 4'b0001,
    RTC_SRC_ALARM = 4'b0010,
    RTC_SRC_1HZ   = 4'b0100,
    RTC_SRC_16HZ  = 4'b1000
  } rtc_src_e;

endpackage

// ==== core/rtc_prescale.sv ====
// Purpose: Binary divider from the 32,768 Hz source down to the one-second carry
// Assumes: tick_32k is synchronous to clk_sys and much slower than it
// Notes:   Not cleared by system reset; only the divider clear input empties it
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_prescale #(
  parameter int STAGES = `RTC_DIV_STAGES
) (
  input  wire logic clk_sys,
  input  wire logic tick_32k,
  input  wire logic div_clear,
  output logic      second_carry,
  output logic      wave_1hz,
  output logic      wave_16hz
);
  logic [STAGES-1:0] div_cnt;
  logic              tick_prev;
  logic              src_edge;

  if (STAGES < `RTC_16HZ_SHIFT + 2) begin : g_chk
    $error("rtc_prescale: STAGES too small for the 16Hz tap");
  end

  assign src_edge = tick_32k & ~tick_prev;

  always_ff @(posedge clk_sys) begin
    tick_prev <= tick_32k;
  end

  // Clear restarts at zero, so the top bit first rises after half a second
  always_ff @(posedge clk_sys) begin
    if (div_clear) begin
      div_cnt <= '0;
    end else if (src_edge) begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // Seconds step on the rising top bit; the pin shows it inverted, so the
  // 1Hz falling edge and the count-up land on the same source tick
  always_ff @(posedge clk_sys) begin
    second_carry <= ~div_clear & src_edge & (div_cnt == {1'b0, {(STAGES-1){1'b1}}});
  end

  assign wave_1hz  = ~div_cnt[STAGES-1];
  assign wave_16hz = ~div_cnt[STAGES-1-`RTC_16HZ_SHIFT];
endmodule

// ==== core/rtc_core.sv ====
// Purpose: RTC time counters, carry hold, alarm compare, alarm pin and irq pulse
// Assumes: Avalon-MM slave with waitrequest; tick_32k synchronous to clk_sys
// Notes:   Clock and alarm state survive rst; only bus, irq enable and irq pulse reset
// Behaviour
// - Time counters advance in the same source tick as the 1Hz interrupt.
// - One-second tick comes from a 15-stage divider on 32,768 Hz; software may clear it.
// - After divider clear the first count-up comes after half a second.
// - Count disabled holds one pending carry; re-enable applies it and resumes.
// - Disabled for a second or more loses the extra seconds.
// - The irq is a one-cycle pulse on a falling edge of the selected pin source.
// - System reset clears no clock or alarm register or counter.
// - With alarm enable set, a full match drives the pin low and raises the irq.
// - Alarm clear sets every alarm field to don't-care.
// - Writing an alarm field stores it and takes it out of don't-care.
// - Don't-care fields always match; an alarm irq needs irq enable and alarm enable.
// - No single field returns to don't-care; only a full alarm clear does.
// - Time writes settle within one 32 kHz cycle; software waits 31us before pin use.
// - Alarm off, 1Hz on, 16Hz off: 1Hz wave on the pin, irq on each fall.
// - Alarm off, 1Hz off, 16Hz on: 16Hz wave on the pin, irq on each fall.
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_core #(
  parameter int DIV_STAGES = `RTC_DIV_STAGES
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                tick_32k,
  input  wire rtc_pkg::rtc_av_req_s av_req,
  output logic                     av_waitrequest,
  output logic [31:0]              av_readdata,
  output logic                     alarm_pin_n,
  output logic                     rtc_irq
);
  import rtc_pkg::*;

  if (DIV_STAGES != `RTC_DIV_STAGES) begin : g_chk
    $error("rtc_core: the seconds tick needs the documented divider length");
  end

  // Page and control bits
  logic       rtc_irq_enable;
  logic       count_enable;
  logic       alarm_enable;
  logic       page_sel;
  logic       one_hz_disable;
  logic       sixteen_hz_disable;

  // Counters and alarm
  rtc_time_s  tm;
  rtc_time_s  next_tm;
  rtc_alarm_s alm;
  logic [3:0] alm_set;
  logic       carry_pending;
  logic       adjust_req;

  // Divider
  logic       second_carry;
  logic       wave_1hz;
  logic       wave_16hz;
  logic       div_clear;

  // Bus
  logic       req;
  logic       acc;
  logic       wr_acc;
  logic [7:0] wd;
  logic [4:0] ad;
  logic [7:0] rd_byte;

  // Alarm compare and pin
  logic       alarm_match;
  rtc_src_e   src_sel;
  logic       next_pin;
  logic       step_sec;

  function automatic logic [7:0] bcd_step(input logic [7:0] v,
                                          input logic [7:0] top,
                                          input logic [7:0] base);
    logic [7:0] r;
    r = v;
    if (v == top) begin
      r = base;
    end else if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  function automatic logic field_ok(input logic set, input logic [7:0] a,
                                    input logic [7:0] t);
    return ~set | (a == t);
  endfunction

  rtc_prescale #(
    .STAGES (DIV_STAGES)
  ) u_div (
    .clk_sys      (clk_sys),
    .tick_32k     (tick_32k),
    .div_clear    (div_clear),
    .second_carry (second_carry),
    .wave_1hz     (wave_1hz),
    .wave_16hz    (wave_16hz)
  );

  // Bus handshake: waitrequest drops one cycle after a request, the access
  // takes effect at the edge where it is low, then rises again
  assign req    = av_req.read | av_req.write;
  assign acc    = req & ~av_waitrequest;
  assign wr_acc = acc & av_req.write;
  assign wd     = av_req.writedata;
  assign ad     = av_req.address;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      av_waitrequest <= 1'b1;
    end else if (acc) begin
      av_waitrequest <= 1'b1;
    end else if (req) begin
      av_waitrequest <= 1'b0;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (ad == `RTC_OFS_SEC) begin
      rd_byte = page_sel ? 8'h00 : tm.sec;
    end else if (ad == `RTC_OFS_MIN) begin
      rd_byte = page_sel ? alm.min : tm.min;
    end else if (ad == `RTC_OFS_HOUR) begin
      rd_byte = page_sel ? alm.hour : tm.hour;
    end else if (ad == `RTC_OFS_WDAY) begin
      rd_byte = page_sel ? alm.wday : tm.wday;
    end else if (ad == `RTC_OFS_DATE) begin
      rd_byte = page_sel ? alm.date : tm.date;
    end else if (ad == `RTC_OFS_PAGE) begin
      rd_byte = {rtc_irq_enable, 3'h0, count_enable, alarm_enable, 1'b0, page_sel}
                & `RTC_PG_RD_MASK;
    end
  end

  // Read data is sampled while waitrequest is still high and stands through
  // the accepting edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      av_readdata <= 32'h0000_0000;
    end else if (req & av_waitrequest) begin
      av_readdata <= av_req.read ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Irq enable resets; the other page bits keep their value over rst
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rtc_irq_enable <= 1'b0;
    end else if (wr_acc && ad == `RTC_OFS_PAGE) begin
      rtc_irq_enable <= wd[`RTC_PG_IRQ_EN];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr_acc && ad == `RTC_OFS_PAGE) begin
      count_enable <= wd[`RTC_PG_CNT_EN];
      alarm_enable <= wd[`RTC_PG_ALM_EN];
      page_sel     <= wd[`RTC_PG_PAGE];
    end
  end

  always_ff @(posedge clk_sys) begin
    adjust_req <= wr_acc && ad == `RTC_OFS_PAGE && wd[`RTC_PG_ADJUST]
                  && !wd[`RTC_PG_PAGE];
  end

  always_ff @(posedge clk_sys) begin
    if (wr_acc && ad == `RTC_OFS_CTRL) begin
      one_hz_disable     <= wd[`RTC_CT_DIS_1HZ];
      sixteen_hz_disable <= wd[`RTC_CT_DIS_16HZ];
    end
  end

  assign div_clear = wr_acc && ad == `RTC_OFS_CTRL && wd[`RTC_CT_DIV_CLR];

  // Carry hold: one bit, so a second held past the next carry is lost
  always_ff @(posedge clk_sys) begin
    if (count_enable) begin
      carry_pending <= 1'b0;
    end else if (second_carry) begin
      carry_pending <= 1'b1;
    end
  end

  assign step_sec = count_enable & (second_carry | carry_pending);

  always_comb begin
    next_tm = tm;
    if (adjust_req) begin
      next_tm.sec = `RTC_ZERO;
    end
    if (step_sec || (adjust_req && tm.sec >= `RTC_SEC_HALF)) begin
      if (step_sec) begin
        next_tm.sec = bcd_step(tm.sec, `RTC_SEC_TOP, `RTC_ZERO);
      end
      if (adjust_req || tm.sec == `RTC_SEC_TOP) begin
        next_tm.min = bcd_step(tm.min, `RTC_MIN_TOP, `RTC_ZERO);
        if (tm.min == `RTC_MIN_TOP) begin
          next_tm.hour = bcd_step(tm.hour, `RTC_HOUR_TOP, `RTC_ZERO);
          if (tm.hour == `RTC_HOUR_TOP) begin
            next_tm.wday = bcd_step(tm.wday, `RTC_WDAY_TOP, `RTC_ZERO);
            next_tm.date = bcd_step(tm.date, `RTC_DATE_TOP, `RTC_DATE_BASE);
          end
        end
      end
    end
    if (wr_acc && !page_sel) begin
      if (ad == `RTC_OFS_SEC) begin
        next_tm.sec = wd;
      end else if (ad == `RTC_OFS_MIN) begin
        next_tm.min = wd;
      end else if (ad == `RTC_OFS_HOUR) begin
        next_tm.hour = wd;
      end else if (ad == `RTC_OFS_WDAY) begin
        next_tm.wday = wd;
      end else if (ad == `RTC_OFS_DATE) begin
        next_tm.date = wd;
      end
    end
  end

  // Time counters ignore rst on purpose
  always_ff @(posedge clk_sys) begin
    tm <= next_tm;
  end

  // Alarm fields and their configured flags
  always_ff @(posedge clk_sys) begin
    if (wr_acc && ad == `RTC_OFS_CTRL && wd[`RTC_CT_ALM_CLR]) begin
      alm_set <= 4'h0;
    end else if (wr_acc && page_sel) begin
      if (ad == `RTC_OFS_MIN) begin
        alm.min    <= wd;
        alm_set[0] <= 1'b1;
      end else if (ad == `RTC_OFS_HOUR) begin
        alm.hour   <= wd;
        alm_set[1] <= 1'b1;
      end else if (ad == `RTC_OFS_WDAY) begin
        alm.wday   <= wd;
        alm_set[2] <= 1'b1;
      end else if (ad == `RTC_OFS_DATE) begin
        alm.date   <= wd;
        alm_set[3] <= 1'b1;
      end
    end
  end

  assign alarm_match = field_ok(alm_set[0], alm.min,  tm.min)
                     & field_ok(alm_set[1], alm.hour, tm.hour)
                     & field_ok(alm_set[2], alm.wday, tm.wday)
                     & field_ok(alm_set[3], alm.date, tm.date);

  always_comb begin
    if (alarm_enable) begin
      src_sel = RTC_SRC_ALARM;
    end else if (!one_hz_disable && sixteen_hz_disable) begin
      src_sel = RTC_SRC_1HZ;
    end else if (one_hz_disable && !sixteen_hz_disable) begin
      src_sel = RTC_SRC_16HZ;
    end else begin
      src_sel = RTC_SRC_NONE;
    end
  end

  always_comb begin
    case (src_sel)
      RTC_SRC_ALARM: next_pin = ~alarm_match;
      RTC_SRC_1HZ:   next_pin = wave_1hz;
      RTC_SRC_16HZ:  next_pin = wave_16hz;
      default:       next_pin = 1'b1;
    endcase
  end

  // Pin level is kept over rst like the rest of the clock state
  always_ff @(posedge clk_sys) begin
    alarm_pin_n <= next_pin;
  end

  // One pulse per falling pin edge, only with irq enable set
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rtc_irq <= 1'b0;
    end else begin
      rtc_irq <= rtc_irq_enable & alarm_pin_n & ~next_pin;
    end
  end
endmodule

// ==== dv/rtc_core_properties.sv ====
// Purpose: Port-level checks of the RTC core
// Assumes: One clock domain, rst synchronous active high
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_core_properties (
  input wire logic                 clk_sys,
  input wire logic                 rst,
  input wire logic                 tick_32k,
  input wire rtc_pkg::rtc_av_req_s av_req,
  input wire logic                 av_waitrequest,
  input wire logic [31:0]          av_readdata,
  input wire logic                 alarm_pin_n,
  input wire logic                 rtc_irq
);
  import rtc_pkg::*;
  logic       tick_d;
  logic [3:0] quiet;
  logic       req;
  assign req = av_req.read | av_req.write;
  always_ff @(posedge clk_sys) begin
    tick_d <= tick_32k;
  end
  // Pin may only move shortly after a source tick or a register write
  always_ff @(posedge clk_sys) begin
    if ((tick_32k & ~tick_d) | (av_req.write & ~av_waitrequest)) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hf) begin
      quiet <= quiet + 4'h1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_taken;
    req && av_waitrequest;
  endsequence
  sequence s_answer;
    !av_waitrequest ##1 av_waitrequest;
  endsequence
  a_bus_answer: assert property (s_taken |=> s_answer)
    else $error("bus answer not one wait cycle");
  a_wait_idle: assert property ((!req && av_waitrequest) |=> av_waitrequest)
    else $error("waitrequest dropped without request");
  a_data_hold: assert property ((!req && av_waitrequest) |=> $stable(av_readdata))
    else $error("read data moved while idle");
  a_data_high: assert property (av_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_read_zero: assert property ((av_req.read && !av_waitrequest
    && av_req.address >= `RTC_OFS_CTRL) |-> av_readdata == 32'h0)
    else $error("control or unmapped read not zero");
  a_irq_fall: assert property (rtc_irq |-> $fell(alarm_pin_n))
    else $error("irq without pin fall");
  a_irq_single: assert property (rtc_irq |=> !rtc_irq)
    else $error("irq longer than one cycle");
  a_pin_cause: assert property ($changed(alarm_pin_n) |-> quiet <= 4'h6)
    else $error("alarm pin moved without cause");
endmodule

// ==== dv/rtc_tick_src.sv ====
// Purpose: 32,768 Hz source model feeding the RTC core
// Assumes: One source period is 2*HALF clk_sys cycles
// Notes:   Runs free like a crystal, so tests do not control its phase
`timescale 1ns/1ps
module rtc_tick_src #(
  parameter int HALF = 2
) (
  input  wire logic clk_sys,
  output logic      tick_32k
);
  int cnt = 0;
  initial tick_32k = 1'b0;
  always @(posedge clk_sys) begin
    if (cnt == HALF - 1) begin
      cnt <= 0;
      tick_32k <= ~tick_32k;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ==== dv/rtc_carry_alarm_output_tb.sv ====
// Purpose: Self-checking bench of the RTC core
// Assumes: Source period of 4 clk_sys cycles, so half a second is 65536 cycles
// Notes:   Run stays short of the next one-second carry, so minutes never roll
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_carry_alarm_output_tb;
  import rtc_pkg::*;
  localparam int LIMIT = 99000;
  logic        clk_sys;
  logic        rst;
  logic        tick_32k;
  rtc_av_req_s av_req;
  logic        av_waitrequest;
  logic [31:0] av_readdata;
  logic        alarm_pin_n;
  logic        rtc_irq;
  logic [31:0] rd_v;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          c;

  rtc_tick_src #(.HALF(2)) u_src (.clk_sys(clk_sys), .tick_32k(tick_32k));
  rtc_core dut (.clk_sys(clk_sys), .rst(rst), .tick_32k(tick_32k), .av_req(av_req),
    .av_waitrequest(av_waitrequest), .av_readdata(av_readdata),
    .alarm_pin_n(alarm_pin_n), .rtc_irq(rtc_irq));

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    av_req <= rtc_av_req_s'{read: ~wr, write: wr, address: a, writedata: d};
    do @(posedge clk_sys); while (av_waitrequest !== 1'b0);
    rd_v = av_readdata;
    av_req <= '0;
  endtask
  task automatic wait_irq(input int lim);
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (rtc_irq !== 1'b1 && c < lim);
  endtask
  task automatic t_carry_hold();
    bus(1'b1, `RTC_OFS_PAGE, 8'h00);
    bus(1'b1, `RTC_OFS_SEC, 8'h58);
    bus(1'b1, `RTC_OFS_MIN, 8'h10);
    bus(1'b1, `RTC_OFS_CTRL, 8'h60);
    bus(1'b1, `RTC_OFS_PAGE, 8'h80);
    wait_irq(70000);
    chk(32'(c >= 65525 && c <= 65545), 32'h1);
    bus(1'b0, `RTC_OFS_SEC, 8'h00);
    chk(rd_v, 32'h58);
    bus(1'b1, `RTC_OFS_PAGE, 8'h88);
    bus(1'b0, `RTC_OFS_SEC, 8'h00);
    chk(rd_v, 32'h59);
  endtask
  task automatic t_sixteen();
    bus(1'b1, `RTC_OFS_CTRL, 8'h80);
    wait_irq(9000);
    wait_irq(9000);
    chk(c, 32'd8192);
  endtask
  task automatic t_alarm();
    bus(1'b1, `RTC_OFS_PAGE, 8'h09);
    bus(1'b1, `RTC_OFS_CTRL, 8'hd0);
    repeat (3) @(posedge clk_sys);
    chk(alarm_pin_n, 32'h1);
    bus(1'b1, `RTC_OFS_PAGE, 8'h0c);
    repeat (3) @(posedge clk_sys);
    chk(alarm_pin_n, 32'h0);
    bus(1'b1, `RTC_OFS_PAGE, 8'h09);
    bus(1'b1, `RTC_OFS_MIN, 8'h45);
    bus(1'b0, `RTC_OFS_MIN, 8'h00);
    chk(rd_v, 32'h45);
    bus(1'b0, `RTC_OFS_SEC, 8'h00);
    chk(rd_v, 32'h0);
    bus(1'b0, 5'h1c, 8'h00);
    chk(rd_v, 32'h0);
    bus(1'b1, `RTC_OFS_PAGE, 8'h0c);
    repeat (3) @(posedge clk_sys);
    chk(alarm_pin_n, 32'h1);
    bus(1'b1, `RTC_OFS_PAGE, 8'h8c);
    bus(1'b1, `RTC_OFS_MIN, 8'h45);
    wait_irq(40);
    chk(32'(c < 40), 32'h1);
    chk(alarm_pin_n, 32'h0);
  endtask
  task automatic t_reset();
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    chk(rtc_irq, 32'h0);
    bus(1'b0, `RTC_OFS_PAGE, 8'h00);
    chk(rd_v, 32'h0c);
    bus(1'b0, `RTC_OFS_MIN, 8'h00);
    chk(rd_v, 32'h45);
    bus(1'b0, `RTC_OFS_MIN, 8'h00);
    chk(rd_v, 32'h45);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    rst = 1'b1;
    av_req = '0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_carry_hold();
    t_sixteen();
    t_alarm();
    t_reset();
    final_report();
  end
endmodule

bind rtc_core rtc_core_properties u_props (.clk_sys(clk_sys), .rst(rst),
  .tick_32k(tick_32k), .av_req(av_req), .av_waitrequest(av_waitrequest),
  .av_readdata(av_readdata), .alarm_pin_n(alarm_pin_n), .rtc_irq(rtc_irq));
